// ### okp_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "okp_params.svh"

module okp_config
  import okp_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Software controls from the engine registers.
  input  wire logic [3:0]                 sw_key_source_sel,
  input  wire logic                       start_req,
  input  wire logic                       otp_program_go,
  input  wire logic [3:0]                 otp_page_select,
  input  wire logic [`OKP_PROG_WIDTH-1:0] text_buffer_c,
  // OTP array macro.
  output var  okp_otp_req_t               otp_req,
  output logic                            otp_read_req,
  input  wire logic                       otp_ack,
  input  wire logic [31:0]                otp_read_data,
  // Policy and status to the engine.
  output var  okp_policy_t                policy,
  output logic [31:0]                     otp_config_page,
  output logic                            program_test_mirror,
  output logic                            program_fail_flag,
  output logic                            program_busy,
  output logic                            config_loaded,
  output logic                            start_grant
);

  // Whole state of the block in one record; one always_comb builds the next copy.
  typedef struct packed {
    // Sequencer and page image.
    okp_state_t   st;
    logic [31:0]  cfg;
    // Requests to the array.
    okp_otp_req_t req;
    logic         rd;
    // Decoded policy and status.
    okp_policy_t  pol;
    logic         mirror;
    logic         pfail;
    logic         busy;
    logic         loaded;
    logic         grant;
    // Program bit as sampled last cycle, kept for edge detection.
    logic         go_q;
  } okp_regs_t;

  // Code space of the page selector; codes past the last page are refused.
  localparam int unsigned PAGE_CODES = 16;

  // Current record and the copy for the next edge.
  okp_regs_t r;
  okp_regs_t next_r;

  // Priority decode of the locked key-source field.
  // The highest set bit wins; an all-zero field falls back to the software-key code.
  function automatic logic [3:0] okp_lock_decode(input logic [7:0] f);
    logic [3:0] sel;
    sel = `OKP_SEL_SW_KEY;
    if (f[7]) begin
      sel = `OKP_SEL_TOP;
    end else begin
      // Scan downwards; the first set bit ends the search.
      for (int i = 6; i >= 0; i--) begin
        if (f[i] && sel == `OKP_SEL_SW_KEY) begin
          sel = 4'(i + 1);
        end
      end
    end
    return sel;
  endfunction : okp_lock_decode

  // Sequencing, decode and program checks, all from the registered record.
  always_comb begin
    logic [3:0]            src;
    logic [`OKP_PAGES-1:0] wlock;
    logic [PAGE_CODES-1:0] lock_map;
    logic                  kfail;
    logic                  go_edge;
    logic                  refused;
    // Defaults first, so every path assigns every local.
    src      = `OKP_SEL_SW_KEY;
    wlock    = r.cfg[`OKP_PAGE_WRITE_LOCK_HI:`OKP_PAGE_WRITE_LOCK_LO];
    // Codes past the last page are padded with ones, so they read as locked pages.
    lock_map = {{(PAGE_CODES - `OKP_PAGES){1'b1}}, wlock};
    kfail    = 1'b0;
    go_edge  = otp_program_go && !r.go_q;
    refused  = lock_map[otp_page_select];
    // Hold every field by default and clear the grant, which is rebuilt from the request below.
    next_r      = r;
    next_r.go_q = otp_program_go;
    next_r.grant = 1'b0;

    // Every code of the state type is used, so the case has no default.
    unique case (r.st)
      // Ask the array for the page image once, right after reset.
      OKP_ST_LOAD: begin
        next_r.rd = 1'b1;
        next_r.st = OKP_ST_WAIT;
      end
      // The read request drops with the answer, so the array sees one read.
      OKP_ST_WAIT: begin
        if (otp_ack) begin
          next_r.rd     = 1'b0;
          next_r.cfg    = otp_read_data;
          next_r.loaded = 1'b1;
          next_r.st     = OKP_ST_RUN;
        end
      end
      // Only a rising edge of the program bit launches a request, so a bit left
      // high after completion cannot program the same page twice.
      OKP_ST_RUN: begin
        if (go_edge) begin
          if (refused) begin
            // A refused request touches no page and leaves the sequencer idle.
            next_r.pfail = 1'b1;
          end else begin
            // Page and data are captured here and stand until the answer.
            next_r.pfail        = 1'b0;
            next_r.req.prog_req = 1'b1;
            next_r.req.page     = otp_page_select;
            next_r.req.data     = text_buffer_c;
            next_r.busy         = 1'b1;
            next_r.st           = OKP_ST_PROG;
          end
        end
      end
      // The request stands until the array acknowledges it.
      OKP_ST_PROG: begin
        if (otp_ack) begin
          next_r.req.prog_req = 1'b0;
          next_r.busy         = 1'b0;
          // OTP only sets bits, so the new page image is an OR.
          // Other pages live in the array only and need no local copy.
          if (r.req.page == `OKP_PAGE_CONFIG) begin
            next_r.cfg = r.cfg | r.req.data[31:0];
          end
          next_r.st = OKP_ST_RUN;
        end
      end
    endcase

    // Key source choice. Before the load the image is all zero, so the lock is off
    // and the software selector passes through; the fail flag still blocks starts.
    if (r.cfg[`OKP_SRC_LOCK_BIT]) begin
      src = okp_lock_decode(r.cfg[`OKP_LKS_HI:`OKP_LKS_LO]);
    end else begin
      src = sw_key_source_sel;
    end

    // Zero selects the software key unless it is disabled; an unloaded image
    // counts as a failure, so no start slips through before the load.
    kfail = !r.loaded || (r.cfg[`OKP_SWKEY_DIS_BIT] && src == `OKP_SEL_SW_KEY);

    // Policy word for the engine, one cycle behind the image and the selector.
    next_r.pol.key_source = src;
    next_r.pol.key_fail_flag = kfail;
    next_r.pol.start_allowed = !kfail && r.loaded;
    // A grant follows a standing request one cycle later and stays high while it stands; a failed key blocks it.
    next_r.grant = start_req && !kfail && r.loaded;

    // Key type restrictions are plain copies of the two-bit fields.
    next_r.pol.keyram_type_sel = okp_key_type_t'(r.cfg[`OKP_KEYRAM_HI:`OKP_KEYRAM_LO]);
    next_r.pol.pg78_type_sel = okp_key_type_t'(r.cfg[`OKP_PG78_HI:`OKP_PG78_LO]);
    next_r.pol.pg56_type_sel = okp_key_type_t'(r.cfg[`OKP_PG56_HI:`OKP_PG56_LO]);
    next_r.pol.pg34_type_sel = okp_key_type_t'(r.cfg[`OKP_PG34_HI:`OKP_PG34_LO]);
    next_r.pol.key1_type_sel = okp_key_type_t'(r.cfg[`OKP_PG12_HI:`OKP_PG12_LO]);
    // Stored key 1 may be limited to wrapping other keys.
    next_r.pol.key1_kek_only = r.cfg[`OKP_KEK_ONLY_BIT];
    // The programmed bit shows in the image and in the program-test mirror.
    next_r.mirror = r.cfg[`OKP_PROGRAMMED_BIT];
  end

  // Single register stage for the whole record. Reset clears the image and the loaded flag;
  // the cleared loaded flag forces the key-fail flag until the load is done.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Array requests, straight from flip-flops.
  assign otp_req             = r.req;
  assign otp_read_req        = r.rd;

  // Decoded policy and page image.
  assign policy              = r.pol;
  assign otp_config_page     = r.cfg;
  assign program_test_mirror = r.mirror;

  // Program and start status.
  assign program_fail_flag   = r.pfail;
  assign program_busy        = r.busy;
  assign config_loaded       = r.loaded;
  assign start_grant         = r.grant;

endmodule : okp_config
`default_nettype wire

// ### okp_config_props.sv
`timescale 1ns/100ps
`default_nettype none
module okp_config_props
  import okp_pkg::*;
(
  // Watched ports of the loader.
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  sw_key_source_sel,
  input wire logic        start_req,
  input wire logic        otp_program_go,
  input wire logic [3:0]  otp_page_select,
  input wire logic        otp_ack,
  input wire okp_otp_req_t otp_req,
  input wire okp_policy_t policy,
  input wire logic [31:0] otp_config_page,
  input wire logic        program_test_mirror,
  input wire logic        program_fail_flag,
  input wire logic        program_busy,
  input wire logic        config_loaded,
  input wire logic        start_grant
);
  // All checks share the one clock domain.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_mirror_copy: assert property (program_test_mirror == $past(otp_config_page[30]))
    else $error("mirror does not follow programmed bit");
  a_type_fields: assert property (policy[16:6] == $past(otp_config_page[29:19]))
    else $error("type fields do not follow page");
  a_src_soft: assert property ($past(config_loaded) && !$past(otp_config_page[10]) |->
    policy.key_source == $past(sw_key_source_sel)) else $error("software selector ignored");
  a_src_locked: assert property ($past(otp_config_page[10]) && $past(otp_config_page[18]) |->
    policy.key_source == 4'hf) else $error("locked top bit not decoded");
  a_key_fail: assert property ($past(otp_config_page[0]) && !$past(otp_config_page[10]) &&
    $past(sw_key_source_sel) == 4'h0 |-> policy.key_fail_flag) else $error("key fail missing");
  a_grant_cause: assert property (start_grant |-> $past(start_req) && $past(config_loaded))
    else $error("grant without request");
  a_go_answer: assert property ($rose(otp_program_go) && config_loaded && !program_busy |=>
    program_busy || program_fail_flag) else $error("program request not answered");
  a_bad_page: assert property ($rose(otp_program_go) && config_loaded && !program_busy &&
    otp_page_select > 4'h8 |=> program_fail_flag && !program_busy) else $error("bad page taken");
  a_ack_ends: assert property (program_busy && otp_ack |=> !program_busy)
    else $error("busy outlives ack");
  a_sw_key_ok: assert property ($past(config_loaded) && !$past(otp_config_page[0]) |->
    !policy.key_fail_flag) else $error("software key refused while enabled");
  a_locked_page: assert property ($rose(otp_program_go) && config_loaded &&
    !program_busy && otp_page_select <= 4'h8 &&
    otp_config_page[5'(otp_page_select) + 5'h1] |=> program_fail_flag && !program_busy)
    else $error("locked page taken");
  a_cfg_program: assert property (program_busy && otp_ack && otp_req.page == 4'h0 |=>
    otp_config_page == ($past(otp_config_page) | $past(otp_req.data[31:0])))
    else $error("configuration page not updated");
endmodule : okp_config_props
bind okp_config okp_config_props u_props (.clk, .rst_n, .sw_key_source_sel, .start_req,
  .otp_program_go, .otp_page_select, .otp_ack, .otp_req, .policy, .otp_config_page,
  .program_test_mirror,
  .program_fail_flag, .program_busy, .config_loaded, .start_grant);
`default_nettype wire

// ### okp_otp_model.sv
`timescale 1ns/100ps
`default_nettype none
module okp_otp_model
  import okp_pkg::*;
(
  // Array side of the loader.
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire okp_otp_req_t otp_req,
  input  wire logic         otp_read_req,
  input  wire logic [31:0]  image,
  input  wire logic [3:0]   lat,
  output logic              otp_ack,
  output logic [31:0]       otp_read_data
);
  logic [3:0] cnt;
  logic       hold;
  // Outside the ack cycle the bus shows the inverse, so a stale copy cannot pass.
  assign otp_read_data = otp_ack ? image : ~image;
  // Answer lat+1 cycles after the request rises, then rest one cycle while the request drops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      hold <= 1'b0;
      otp_ack <= 1'b0;
    end else if (otp_ack || hold) begin
      otp_ack <= 1'b0;
      hold <= otp_ack;
    end else if (otp_req.prog_req || otp_read_req) begin
      otp_ack <= (cnt == lat);
      cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule : okp_otp_model
`default_nettype wire

// ### okp_params.svh
`ifndef OKP_PARAMS_SVH
`define OKP_PARAMS_SVH
// Configuration page field positions.
`define OKP_PROGRAMMED_BIT  30
`define OKP_KEYRAM_HI       29
`define OKP_KEYRAM_LO       28
`define OKP_PG78_HI         27
`define OKP_PG78_LO         26
`define OKP_PG56_HI         25
`define OKP_PG56_LO         24
`define OKP_PG34_HI         23
`define OKP_PG34_LO         22
`define OKP_PG12_HI         21
`define OKP_PG12_LO         20
`define OKP_KEK_ONLY_BIT    19
`define OKP_LKS_HI          18
`define OKP_LKS_LO          11
`define OKP_SRC_LOCK_BIT    10
`define OKP_PAGE_WRITE_LOCK_HI       9
`define OKP_PAGE_WRITE_LOCK_LO       1
`define OKP_SWKEY_DIS_BIT   0
// Codes and counts.
`define OKP_SEL_SW_KEY      4'h0
`define OKP_SEL_TOP         4'hf
`define OKP_PAGE_CONFIG     4'h0
`define OKP_PAGE_LAST       4'h8
`define OKP_PAGES           9
`define OKP_PROG_WIDTH      64
`endif

// ### okp_pkg.sv
`default_nettype none
package okp_pkg;
  // Key type restriction encoding shared by all type fields.
  typedef enum logic [1:0] {
    OKP_KT_DES12  = 2'h0,
    OKP_KT_DES3   = 2'h1,
    OKP_KT_AES128 = 2'h2,
    OKP_KT_AES256 = 2'h3
  } okp_key_type_t;

  // Gray-coded sequence: load at power-on, run, program.
  typedef enum logic [1:0] {
    OKP_ST_LOAD = 2'h0,
    OKP_ST_WAIT = 2'h1,
    OKP_ST_RUN  = 2'h3,
    OKP_ST_PROG = 2'h2
  } okp_state_t;

  // Decoded key policy handed to the cipher engine.
  typedef struct packed {
    okp_key_type_t keyram_type_sel;
    okp_key_type_t pg78_type_sel;
    okp_key_type_t pg56_type_sel;
    okp_key_type_t pg34_type_sel;
    okp_key_type_t key1_type_sel;
    logic          key1_kek_only;
    logic [3:0]    key_source;
    logic          key_fail_flag;
    logic          start_allowed;
  } okp_policy_t;

  // Request to the OTP array macro.
  typedef struct packed {
    logic        prog_req;
    logic [3:0]  page;
    logic [63:0] data;
  } okp_otp_req_t;
endpackage : okp_pkg
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import okp_pkg::*;
  logic clk, rst_n, start_req, otp_program_go, otp_read_req, otp_ack, bad;
  logic program_test_mirror, program_fail_flag, program_busy, config_loaded, start_grant;
  logic [3:0] sw_key_source_sel, otp_page_select, lat;
  logic [31:0] otp_read_data, otp_config_page, image, cfg, s = 32'h00000025;
  logic [63:0] text_buffer_c;
  okp_otp_req_t otp_req;
  okp_policy_t policy;
  int fail_count, checked, ks, pg;
  okp_config uut (.clk, .rst_n, .sw_key_source_sel, .start_req, .otp_program_go,
    .otp_page_select, .text_buffer_c, .otp_req, .otp_read_req, .otp_ack, .otp_read_data,
    .policy, .otp_config_page, .program_test_mirror, .program_fail_flag, .program_busy,
    .config_loaded, .start_grant);
  okp_otp_model u_otp (.clk, .rst_n, .otp_req, .otp_read_req, .image, .lat, .otp_ack,
    .otp_read_data);
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  // Reference selector: lock picks the highest set locked bit, else software wins.
  function automatic int ref_src(logic [31:0] c, logic [3:0] sw);
    if (!c[10]) return sw;
    if (c[18]) return 15;
    for (int i = 6; i >= 0; i--) begin
      if (c[11 + i]) return i + 1;
    end
    return 0;
  endfunction : ref_src
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Every drive lands the same small delay after a rising edge.
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run is a few hundred cycles; this limit is far beyond it.
  initial begin
    #50000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rst_n, start_req, otp_program_go, sw_key_source_sel, otp_page_select, lat} = '0;
    text_buffer_c = '0;
    image = '0;
    for (int it = 0; it < 8; it++) begin
      image = rnd();
      lat = 4'(rnd() % 4);
      start_req = 1'b1;
      rst_n = 1'b0;
      tick(12);
      rst_n = 1'b1;
      tick(1);
      chk("fail_unloaded", 1, policy.key_fail_flag);
      chk("grant_unloaded", 0, start_grant);
      chk("read_req", 1, otp_read_req);
      for (int w = 0; w < 40 && config_loaded !== 1'b1; w++) tick(1);
      chk("loaded", 1, config_loaded);
      chk("read_done", 0, otp_read_req);
      cfg = image;
      for (int j = 0; j < 4; j++) begin
        sw_key_source_sel = (j == 0) ? 4'h0 : 4'(rnd());
        start_req = 1'(rnd());
        tick(3);
        ks = ref_src(cfg, sw_key_source_sel);
        chk("key_source", ks, policy.key_source);
        chk("key_fail", cfg[0] && ks == 0, policy.key_fail_flag);
        chk("start_grant", start_req && !(cfg[0] && ks == 0), start_grant);
        chk("start_allowed", !(cfg[0] && ks == 0), policy.start_allowed);
        chk("types", cfg[29:19], policy[16:6]);
        chk("mirror", cfg[30], program_test_mirror);
      end
      pg = (it % 2) ? int'(rnd() % 16) : 0;
      otp_page_select = 4'(pg);
      text_buffer_c = {rnd(), rnd()};
      bad = pg > 8 || cfg[pg + 1];
      otp_program_go = 1'b1;
      tick(2);
      chk("busy", !bad, program_busy);
      chk("fail_early", bad, program_fail_flag);
      chk("req_go", !bad, otp_req.prog_req);
      if (!bad) begin
        chk("req_page", pg, otp_req.page);
        chk("req_lo", text_buffer_c[31:0], otp_req.data[31:0]);
        chk("req_hi", text_buffer_c[63:32], otp_req.data[63:32]);
      end
      for (int w = 0; w < 40 && program_busy !== 1'b0; w++) tick(1);
      chk("busy_end", 0, program_busy);
      otp_program_go = 1'b0;
      tick(2);
      chk("program_fail", bad, program_fail_flag);
      if (!bad && pg == 0) cfg = cfg | text_buffer_c[31:0];
      chk("config", cfg, otp_config_page);
      chk("mirror_after", cfg[30], program_test_mirror);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
